/* File: rtl/ars_map.svh */
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ARS_OFF_STATUS 8'h00
`define ARS_OFF_ENABLE 8'h04
`define ARS_OFF_CLEAR 8'h08

// ----------------------------------------
// Flag layout
// ----------------------------------------
`define ARS_FLAG_W 23
`define ARS_CHAN_N 7
`define ARS_BIT_ADDR_RDY 22
`define ARS_BIT_DATA_RDY 21
`define ARS_REQ_MSB 20
`define ARS_REQ_LSB 14
`define ARS_OV_MSB 13
`define ARS_OV_LSB 7
`define ARS_UN_MSB 6
`define ARS_UN_LSB 0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define ARS_FLAG_RST 23'h00_0000
`define ARS_WORD_ZERO 32'h0000_0000
`define ARS_RESP_OKAY 2'h0
`define ARS_RESP_SLVERR 2'h2

`endif

/* File: rtl/ars_pkg.sv */
package ars_pkg;

    // ----------------------------------------
    // Bus channel states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ARS_WR_IDLE = 2'b01,
        ARS_WR_RESP = 2'b10
    } ars_wr_state_e;

    typedef enum logic [1:0] {
        ARS_RD_IDLE = 2'b01,
        ARS_RD_DATA = 2'b10
    } ars_rd_state_e;

    typedef logic [22:0] ars_flags_t;

    // Complete state of the bus slave
    typedef struct packed {
        ars_wr_state_e wr_state;
        ars_rd_state_e rd_state;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ars_axi_s;

    typedef struct packed {
        ars_flags_t status;
    } ars_sticky_s;

    typedef struct packed {
        ars_flags_t enable;
    } ars_gate_s;

endpackage

/* File: rtl/ars_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Carries flag events, clears and enable writes between the slave and its banks
interface ars_irq_if;
    import ars_pkg::*;
    ars_flags_t set_vec;
    ars_flags_t clr_vec;
    ars_flags_t status;
    ars_flags_t enable;
    ars_flags_t enable_wdata;
    ars_flags_t enable_wmask;
    logic enable_we;
    logic irq;

    modport bank (input set_vec, input clr_vec, output status);
    modport gate (input status, input enable_we, input enable_wdata, input enable_wmask,
                  output enable, output irq);
    modport ctrl (output set_vec, output clr_vec, output enable_we, output enable_wdata,
                  output enable_wmask, input status, input enable, input irq);
endinterface

`default_nettype wire

/* File: rtl/ars_sticky_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module ars_sticky_flags
    import ars_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    ars_irq_if.bank flags
);
`include "ars_map.svh"

    ars_sticky_s state_reg;
    ars_sticky_s state_next;

    // Set applied after clear, so an event in the clear cycle survives
    always_comb begin
        state_next = state_reg;
        state_next.status = (state_reg.status & ~flags.clr_vec) | flags.set_vec;
    end

    // Only reset reinitialises; standby has no path in here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg.status <= `ARS_FLAG_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags.status = state_reg.status;

endmodule

`default_nettype wire

/* File: rtl/ars_irq_gate.sv */
`timescale 1ns/1ps
`default_nettype none

module ars_irq_gate
    import ars_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    ars_irq_if.gate gate
);
`include "ars_map.svh"

    ars_gate_s state_reg;
    ars_gate_s state_next;

    // Byte-lane masked update of the enable bits
    always_comb begin
        state_next = state_reg;
        if (gate.enable_we) begin
            state_next.enable = (state_reg.enable & ~gate.enable_wmask)
                              | (gate.enable_wdata & gate.enable_wmask);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg.enable <= `ARS_FLAG_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign gate.enable = state_reg.enable;
    // Level output, follows flags and enables with no extra delay
    assign gate.irq = |(gate.status & state_reg.enable);

endmodule

`default_nettype wire

/* File: rtl/ars_rx_status_irq.sv */
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ars_rx_status_irq
    import ars_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive controller events, sampled every cycle while high
    input wire logic status_address_ready,
    input wire logic status_data_ready,
    input wire logic left_pcm_rx_request,
    input wire logic right_pcm_rx_request,
    input wire logic line1_rx_request,
    input wire logic microphone_rx_request,
    input wire logic line2_rx_request,
    input wire logic headset_rx_request,
    input wire logic io_ctl_stat_rx_request,
    input wire logic left_pcm_rx_overrun,
    input wire logic right_pcm_rx_overrun,
    input wire logic line1_rx_overrun,
    input wire logic microphone_rx_overrun,
    input wire logic line2_rx_overrun,
    input wire logic headset_rx_overrun,
    input wire logic io_ctl_stat_rx_overrun,
    input wire logic left_pcm_rx_underrun,
    input wire logic right_pcm_rx_underrun,
    input wire logic line1_rx_underrun,
    input wire logic microphone_rx_underrun,
    input wire logic line2_rx_underrun,
    input wire logic headset_rx_underrun,
    input wire logic io_ctl_stat_rx_underrun,
    // Level interrupt to the system
    output logic rx_irq
);
`include "ars_map.svh"

    // ----------------------------------------
    // Flag bank and interrupt gate
    // ----------------------------------------
    ars_irq_if flags_if ();

    ars_sticky_flags u_sticky (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flags(flags_if.bank)
    );

    ars_irq_gate u_gate (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .gate(flags_if.gate)
    );

    // ----------------------------------------
    // Event vector assembly
    // ----------------------------------------
    logic [`ARS_CHAN_N-1:0] req_vec;
    logic [`ARS_CHAN_N-1:0] ov_vec;
    logic [`ARS_CHAN_N-1:0] un_vec;

    // Left PCM lands on the highest bit of each group
    assign req_vec = {left_pcm_rx_request, right_pcm_rx_request, line1_rx_request,
                      microphone_rx_request, line2_rx_request, headset_rx_request,
                      io_ctl_stat_rx_request};
    assign ov_vec = {left_pcm_rx_overrun, right_pcm_rx_overrun, line1_rx_overrun,
                     microphone_rx_overrun, line2_rx_overrun, headset_rx_overrun,
                     io_ctl_stat_rx_overrun};
    assign un_vec = {left_pcm_rx_underrun, right_pcm_rx_underrun, line1_rx_underrun,
                     microphone_rx_underrun, line2_rx_underrun, headset_rx_underrun,
                     io_ctl_stat_rx_underrun};

    // A request stays asserted until the FIFO is drained, so its flag refills
    // after a clear for as long as the FIFO remains half full
    always_comb begin
        flags_if.set_vec = `ARS_FLAG_RST;
        flags_if.set_vec[`ARS_BIT_ADDR_RDY] = status_address_ready;
        flags_if.set_vec[`ARS_BIT_DATA_RDY] = status_data_ready;
        flags_if.set_vec[`ARS_REQ_MSB:`ARS_REQ_LSB] = req_vec;
        flags_if.set_vec[`ARS_OV_MSB:`ARS_OV_LSB] = ov_vec;
        flags_if.set_vec[`ARS_UN_MSB:`ARS_UN_LSB] = un_vec;
    end

    // ----------------------------------------
    // Bus slave state
    // ----------------------------------------
    ars_axi_s state_reg;
    ars_axi_s state_next;

    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] wr_mask;
    logic wr_fire;
    logic [7:0] rd_addr;
    logic ar_take;

    // Address and data are accepted independently and in either order
    // Each half waits in the state struct until its partner arrives; the
    // response is queued only once both are in hand
    assign s_axi_awready = (state_reg.wr_state == ARS_WR_IDLE) && !state_reg.aw_got;
    assign s_axi_wready = (state_reg.wr_state == ARS_WR_IDLE) && !state_reg.w_got;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign aw_have = state_reg.aw_got || aw_take;
    assign w_have = state_reg.w_got || w_take;
    assign wr_fire = aw_have && w_have;
    assign wr_addr = state_reg.aw_got ? state_reg.awaddr : s_axi_awaddr[7:0];
    assign wr_data = state_reg.w_got ? state_reg.wdata : s_axi_wdata;
    assign wr_strb = state_reg.w_got ? state_reg.wstrb : s_axi_wstrb;

    // Byte strobes widened to a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_mask[i*8 +: 8] = {8{wr_strb[i]}};
        end
    end

    // ----------------------------------------
    // Register write decode
    // ----------------------------------------
    // Reserved bits 31..23 are dropped by the slice to the flag width
    always_comb begin
        flags_if.clr_vec = `ARS_FLAG_RST;
        flags_if.enable_we = 1'b0;
        flags_if.enable_wdata = wr_data[`ARS_FLAG_W-1:0];
        flags_if.enable_wmask = wr_mask[`ARS_FLAG_W-1:0];
        if (wr_fire) begin
            case (wr_addr)
                `ARS_OFF_ENABLE: begin
                    flags_if.enable_we = 1'b1;
                end
                `ARS_OFF_CLEAR: begin
                    flags_if.clr_vec = wr_data[`ARS_FLAG_W-1:0] & wr_mask[`ARS_FLAG_W-1:0];
                end
                default: begin
                    flags_if.clr_vec = `ARS_FLAG_RST;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Status is captured on the edge that takes the address, so an event in
    // that same cycle lands in the flags but shows only on the next read.
    // Protection bits mean nothing here and every access is served alike;
    // only the low eight address bits are decoded, so wider buses alias.
    assign s_axi_arready = (state_reg.rd_state == ARS_RD_IDLE);
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr[7:0];

    // ----------------------------------------
    // Next state of both channels
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg.wr_state)
            ARS_WR_IDLE: begin
                if (aw_take) begin
                    state_next.aw_got = 1'b1;
                    state_next.awaddr = s_axi_awaddr[7:0];
                end
                if (w_take) begin
                    state_next.w_got = 1'b1;
                    state_next.wdata = s_axi_wdata;
                    state_next.wstrb = s_axi_wstrb;
                end
                if (wr_fire) begin
                    state_next.wr_state = ARS_WR_RESP;
                    state_next.aw_got = 1'b0;
                    state_next.w_got = 1'b0;
                    // Status is read-only; writing it is refused like a hole
                    if (wr_addr == `ARS_OFF_ENABLE || wr_addr == `ARS_OFF_CLEAR) begin
                        state_next.bresp = `ARS_RESP_OKAY;
                    end else begin
                        state_next.bresp = `ARS_RESP_SLVERR;
                    end
                end
            end
            ARS_WR_RESP: begin
                if (s_axi_bready) begin
                    state_next.wr_state = ARS_WR_IDLE;
                end
            end
            default: begin
                state_next.wr_state = ARS_WR_IDLE;
            end
        endcase

        case (state_reg.rd_state)
            ARS_RD_IDLE: begin
                if (ar_take) begin
                    state_next.rd_state = ARS_RD_DATA;
                    state_next.rresp = `ARS_RESP_OKAY;
                    state_next.rdata = `ARS_WORD_ZERO;
                    case (rd_addr)
                        `ARS_OFF_STATUS: begin
                            state_next.rdata[`ARS_FLAG_W-1:0] = flags_if.status;
                        end
                        // Enable and clear are write-only and read back as zero
                        `ARS_OFF_ENABLE: begin
                            state_next.rdata = `ARS_WORD_ZERO;
                        end
                        `ARS_OFF_CLEAR: begin
                            state_next.rdata = `ARS_WORD_ZERO;
                        end
                        default: begin
                            state_next.rresp = `ARS_RESP_SLVERR;
                        end
                    endcase
                end
            end
            ARS_RD_DATA: begin
                if (s_axi_rready) begin
                    state_next.rd_state = ARS_RD_IDLE;
                end
            end
            default: begin
                state_next.rd_state = ARS_RD_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg.wr_state <= ARS_WR_IDLE;
            state_reg.rd_state <= ARS_RD_IDLE;
            state_reg.aw_got <= 1'b0;
            state_reg.w_got <= 1'b0;
            state_reg.awaddr <= 8'h00;
            state_reg.wdata <= `ARS_WORD_ZERO;
            state_reg.wstrb <= 4'h0;
            state_reg.bresp <= `ARS_RESP_OKAY;
            state_reg.rdata <= `ARS_WORD_ZERO;
            state_reg.rresp <= `ARS_RESP_OKAY;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_bvalid = (state_reg.wr_state == ARS_WR_RESP);
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = (state_reg.rd_state == ARS_RD_DATA);
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign rx_irq = flags_if.irq;

endmodule

`default_nettype wire

/* File: testbench/ars_rx_status_irq_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checks for the receive status block
// ----------------------------------------
module ars_rx_status_irq_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic status_address_ready,
    input wire logic status_data_ready,
    input wire logic rx_irq
);
    // One clock domain, so one default clock and reset
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    rsv_bits_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:23] == 9'h000)
        else $error("reserved read bits set");
    reset_idle_a: assert property ($rose(rst_n) |-> !s_axi_rvalid && !s_axi_bvalid && !rx_irq)
        else $error("outputs busy after reset");
    addr_ready_flag_a: assert property (status_address_ready ##1
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0) |=> s_axi_rdata[22])
        else $error("address ready flag missing");
    data_ready_flag_a: assert property (status_data_ready ##1
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == '0) |=> s_axi_rdata[21])
        else $error("data ready flag missing");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule

bind ars_rx_status_irq ars_rx_status_irq_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status_address_ready(status_address_ready),
    .status_data_ready(status_data_ready),
    .rx_irq(rx_irq)
);

`default_nettype wire

/* File: testbench/ars_rx_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Receive controller event source
// ----------------------------------------
module ars_rx_codec_model (
    input wire logic clk_sys,
    output logic [22:0] ev
);
    // Quiet until a burst of events is asked for
    initial ev = 23'h00_0000;

    // Hold events for n cycles, then drop them all back to zero
    task automatic pulse(input logic [22:0] v, input int n);
        @(posedge clk_sys);
        ev <= v;
        repeat (n) @(posedge clk_sys);
        ev <= 23'h00_0000;
    endtask
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys, rst_n, awv, wv, bre, arv, rre;
    logic [7:0] awa, ara;
    logic [3:0] ws;
    logic [31:0] wd, v, e;
    wire logic [22:0] ev;
    wire logic awr, wr, bv, arr, rv, irq;
    wire logic [1:0] br, rr;
    wire logic [31:0] rd;
    int bad_count, n_tests, i;

    // ----------------------------------------
    // Clock, design and event source
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ars_rx_status_irq #(.ADDR_W(8)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .status_address_ready(ev[22]), .status_data_ready(ev[21]),
        .left_pcm_rx_request(ev[20]), .right_pcm_rx_request(ev[19]),
        .line1_rx_request(ev[18]), .microphone_rx_request(ev[17]),
        .line2_rx_request(ev[16]), .headset_rx_request(ev[15]),
        .io_ctl_stat_rx_request(ev[14]), .left_pcm_rx_overrun(ev[13]),
        .right_pcm_rx_overrun(ev[12]), .line1_rx_overrun(ev[11]),
        .microphone_rx_overrun(ev[10]), .line2_rx_overrun(ev[9]),
        .headset_rx_overrun(ev[8]), .io_ctl_stat_rx_overrun(ev[7]),
        .left_pcm_rx_underrun(ev[6]), .right_pcm_rx_underrun(ev[5]),
        .line1_rx_underrun(ev[4]), .microphone_rx_underrun(ev[3]),
        .line2_rx_underrun(ev[2]), .headset_rx_underrun(ev[1]),
        .io_ctl_stat_rx_underrun(ev[0]), .rx_irq(irq)
    );

    ars_rx_codec_model src (.clk_sys(clk_sys), .ev(ev));

    // ----------------------------------------
    // Expectations, comparison and bus tasks
    // ----------------------------------------
    function automatic logic [31:0] flag_word(input int b);
        return 32'h0000_0001 << b;
    endfunction

    function automatic logic exp_irq(input logic [31:0] s, input logic [31:0] m);
        return |(s & m & 32'h007f_ffff);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Handshakes sampled at the falling edge, where inputs are settled
    task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic at, wt, bt;
        logic [1:0] r;
        int n, k;
        k = $urandom % 3;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(negedge clk_sys);
            at = awv && awr;
            wt = wv && wr;
            bt = bv && bre;
            r = br;
            @(posedge clk_sys);
            n++;
            if (at) awv <= 1'b0;
            if (wt) wv <= 1'b0;
            if (bt) bre <= 1'b0;
            else if (n >= k) bre <= 1'b1;
        end while (!bt);
        @(posedge clk_sys);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Read with a random stall of the data channel
    task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic at, rt;
        logic [31:0] d;
        logic [1:0] r;
        int n, k;
        k = $urandom % 3;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        do begin
            @(negedge clk_sys);
            at = arv && arr;
            rt = rv && rre;
            d = rd;
            r = rr;
            @(posedge clk_sys);
            n++;
            if (at) arv <= 1'b0;
            if (rt) rre <= 1'b0;
            else if (n >= k) rre <= 1'b1;
        end while (!rt);
        @(posedge clk_sys);
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic irqchk(input logic x);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, x});
        @(posedge clk_sys);
    endtask

    task automatic summarize();
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        awv = 1'b0;
        wv = 1'b0;
        bre = 1'b0;
        arv = 1'b0;
        rre = 1'b0;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h0000_0000;
        ws = 4'hf;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(32'h4b33438a));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(8'h00, 32'h0000_0000, 2'h0);
        irqchk(1'b0);
        rdchk(8'h04, 32'h0000_0000, 2'h0);
        rdchk(8'h10, 32'h0000_0000, 2'h2);
        // Each flag alone: position, gating by its own enable, clear
        for (i = 0; i < 23; i++) begin
            src.pulse(23'h00_0001 << i, 1);
            rdchk(8'h00, flag_word(i), 2'h0);
            wrchk(8'h04, ~flag_word(i), 2'h0);
            irqchk(1'b0);
            wrchk(8'h04, flag_word(i), 2'h0);
            irqchk(1'b1);
            wrchk(8'h08, flag_word(i), 2'h0);
            irqchk(1'b0);
            rdchk(8'h00, 32'h0000_0000, 2'h0);
        end
        // Random mixes; status writes must be refused and change nothing
        for (i = 0; i < 20; i++) begin
            v = $urandom & 32'h007f_ffff;
            e = $urandom;
            src.pulse(v[22:0], 1 + $urandom % 3);
            wrchk(8'h04, e, 2'h0);
            irqchk(exp_irq(v, e));
            wrchk(8'h00, 32'h0000_0000, 2'h2);
            rdchk(8'h00, v, 2'h0);
            wrchk(8'h08, 32'h007f_ffff, 2'h0);
        end
        // Flags and enables stay put while idle; a byte-2-only enable write
        // keeps the low enable bytes; then a reset mid-run
        wrchk(8'h04, 32'h007f_ffff, 2'h0);
        ws <= 4'h4;
        src.pulse(23'h40_0001, 1);
        wrchk(8'h04, 32'h0040_0000, 2'h0);
        ws <= 4'hf;
        repeat (50) @(posedge clk_sys);
        rdchk(8'h00, 32'h0040_0001, 2'h0);
        wrchk(8'h08, 32'h0040_0000, 2'h0);
        irqchk(1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(8'h00, 32'h0000_0000, 2'h0);
        src.pulse(23'h40_0000, 1);
        irqchk(1'b0);
        summarize();
    end

    // Watchdog far beyond the thousand or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end
endmodule

`default_nettype wire
